// *** hdl/eth_tail_regs.v ***
//
// Contract
// - Address 7Bh holds the 8-bit read/write tenth level of preset two.
// - Address 7Ch holds the 8-bit read/write eleventh level of preset two.
// - Address 7Dh holds the 8-bit read/write twelfth level of preset two.
// - Bits 3:0 of 7Eh hold the writable sign-magnitude level offset.
// - Bits 7:4 of 7Eh are reserved and cannot be written.
// - The checksum is a CRC of the map and ignores host writes.
// - Level, offset and checksum fields have no reset value.
// - Address 7Ah holds the 8-bit read/write ninth level of preset two.
//
`timescale 1ns/1ps
`default_nettype none
`include "eth_consts.vh"

module eth_tail_regs #(
   parameter DEPTH = `ETH_MAP_DEPTH
) (
   // Clock and reset
   input wire REF_CLK,
   input wire RESET,
   // Register access from the serial interface logic
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output reg [7:0] REG_RDATA,
   output reg REG_RVALID,
   // Status
   output reg CRC_BUSY
);

   localparam AW = `ETH_MAP_AW;
   // Last map index, cut to the walk counter's width on purpose
   localparam [AW-1:0] LAST_IDX = DEPTH[AW-1:0] - 1'b1;
   // Source of a read answer
   localparam [1:0] SRC_NONE = 2'b00;
   localparam [1:0] SRC_MAP = 2'b01;
   localparam [1:0] SRC_SUM = 2'b10;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // The checksum byte sits just above the map and is left out of it
   function in_map;
      input [7:0] a;
      begin
         in_map = (a >= `ETH_MAP_BASE) && (a <= `ETH_MAP_LAST);
      end
   endfunction

   function [AW-1:0] map_index;
      input [7:0] a;
      reg [7:0] t;
      begin
         t = a - `ETH_MAP_BASE;
         map_index = t[AW-1:0];
      end
   endfunction

   // One byte per call; eight shift stages fit in one cycle at this clock,
   // so the walk covers a byte per clock rather than a bit
   function [7:0] crc8;
      input [7:0] c;
      input [7:0] d;
      integer i;
      reg [7:0] r;
      begin
         r = c ^ d;
         for (i = 0; i < 8; i = i + 1) begin
            if (r[7]) begin
               r = {r[6:0], 1'b0} ^ `ETH_CRC_POLY;
            end else begin
               r = {r[6:0], 1'b0};
            end
         end
         crc8 = r;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Decode and map storage
   // ----------------------------------------------------------------------
   wire wr_map = REG_WR & in_map(REG_ADDR);
   wire rd_map = REG_RD & in_map(REG_ADDR);
   wire rd_crc = REG_RD & (REG_ADDR == `ETH_ADDR_CHECKSUM);
   wire [7:0] mem_rdata;
   reg [7:0] wr_data_m;
   reg [AW-1:0] walk_q;
   reg issue_done_q;
   reg issued_q;
   reg issued_last_q;
   reg [7:0] crc_run_q;
   reg [7:0] crc_q;
   reg rd_pend_q;
   reg [1:0] rd_src_q;
   reg [1:0] rd_src_d;
   wire walk_issue = CRC_BUSY & ~issue_done_q & ~rd_map & ~wr_map;
   wire [7:0] crc_next = crc8(crc_run_q, mem_rdata);

   always @* begin
      // Levels nine to twelve store the full byte
      wr_data_m = REG_WDATA;
      if (REG_ADDR == `ETH_ADDR_LEVEL_OFFSET) begin
         // Reserved nibble is dropped so it reads back as zero once the offset has been written
         wr_data_m = REG_WDATA & `ETH_OFFSET_MASK;
      end
   end

   // Host map reads take the single read port; the checksum walk waits
   eth_map_mem #(
      .WIDTH(8),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .clk(REF_CLK),
      .wr_en(wr_map),
      .wr_addr(map_index(REG_ADDR)),
      .wr_data(wr_data_m),
      .rd_addr(rd_map ? map_index(REG_ADDR) : walk_q),
      .rd_data(mem_rdata)
   );

   // ----------------------------------------------------------------------
   // Checksum walk
   // ----------------------------------------------------------------------
   // A map write during a walk restarts it, so the result always covers
   // the latest contents; writes faster than a walk keep it busy.
   // A host read of the map takes the port for that cycle; the walk holds
   // its index and issues it again on the next free cycle.
   always @(posedge REF_CLK) begin
      if (RESET) begin
         CRC_BUSY <= 1'b0;
         walk_q <= {AW{1'b0}};
         issue_done_q <= 1'b0;
         issued_q <= 1'b0;
         issued_last_q <= 1'b0;
         crc_run_q <= `ETH_CRC_INIT;
      end else if (wr_map) begin
         CRC_BUSY <= 1'b1;
         walk_q <= {AW{1'b0}};
         issue_done_q <= 1'b0;
         issued_q <= 1'b0;
         issued_last_q <= 1'b0;
         crc_run_q <= `ETH_CRC_INIT;
      end else begin
         if (issued_q) begin
            crc_run_q <= crc_next;
            if (issued_last_q) begin
               CRC_BUSY <= 1'b0;
            end
         end
         issued_q <= walk_issue;
         issued_last_q <= walk_issue & (walk_q == LAST_IDX);
         if (walk_issue) begin
            walk_q <= walk_q + 1'b1;
            if (walk_q == LAST_IDX) begin
               issue_done_q <= 1'b1;
            end
         end
      end
   end

   // Result register has no reset; it is undefined until the first walk.
   // Only the last byte of an undisturbed walk loads it, so a read during
   // a walk still returns the previous checksum.
   always @(posedge REF_CLK) begin
      if (!RESET && !wr_map && issued_q && issued_last_q) begin
         crc_q <= crc_next;
      end
   end

   // ----------------------------------------------------------------------
   // Read source select
   // ----------------------------------------------------------------------
   always @* begin
      rd_src_d = SRC_NONE;
      if (rd_map) begin
         rd_src_d = SRC_MAP;
      end else if (rd_crc) begin
         rd_src_d = SRC_SUM;
      end
   end

   // ----------------------------------------------------------------------
   // Read return
   // ----------------------------------------------------------------------
   // The map byte leaves the memory one edge after the request, so the
   // source is staged once and valid and data go out together after it.
   always @(posedge REF_CLK) begin
      if (RESET) begin
         rd_pend_q <= 1'b0;
         rd_src_q <= SRC_NONE;
         REG_RVALID <= 1'b0;
         REG_RDATA <= `ETH_RDATA_RESET;
      end else begin
         rd_pend_q <= REG_RD;
         rd_src_q <= rd_src_d;
         REG_RVALID <= rd_pend_q;
         // Data only change with an answer and stand until the next one
         if (rd_pend_q) begin
            case (rd_src_q)
               SRC_MAP: begin
                  REG_RDATA <= mem_rdata;
               end
               SRC_SUM: begin
                  // Writes to the checksum address decode to nothing
                  REG_RDATA <= crc_q;
               end
               default: begin
                  // Unmapped addresses answer with zero
                  REG_RDATA <= `ETH_RDATA_RESET;
               end
            endcase
         end
      end
   end

endmodule // eth_tail_regs

`default_nettype wire

// *** hdl/eth_consts.vh ***
`ifndef ETH_CONSTS_VH
`define ETH_CONSTS_VH

// ----------------------------------------------------------------------
// Threshold map window (both presets, checksum byte excluded)
// ----------------------------------------------------------------------
`define ETH_MAP_BASE 8'h5f
`define ETH_MAP_LAST 8'h7e
`define ETH_MAP_DEPTH 32
`define ETH_MAP_AW 5

// ----------------------------------------------------------------------
// Register offsets of the tail
// ----------------------------------------------------------------------
`define ETH_ADDR_LEVEL_NINE 8'h7a
`define ETH_ADDR_LEVEL_TEN 8'h7b
`define ETH_ADDR_LEVEL_ELEVEN 8'h7c
`define ETH_ADDR_LEVEL_TWELVE 8'h7d
`define ETH_ADDR_LEVEL_OFFSET 8'h7e
`define ETH_ADDR_CHECKSUM 8'h7f

// ----------------------------------------------------------------------
// Field layout of the offset register
// ----------------------------------------------------------------------
`define ETH_OFFSET_MSB 3
`define ETH_OFFSET_LSB 0
`define ETH_OFFSET_MASK 8'h0f
`define ETH_RSVD_MASK 8'hf0

// ----------------------------------------------------------------------
// Checksum: CRC-8, polynomial x^8+x^2+x+1, MSB first
// ----------------------------------------------------------------------
`define ETH_CRC_POLY 8'h07
`define ETH_CRC_INIT 8'hff
`define ETH_RDATA_RESET 8'h00

`endif

// *** hdl/eth_map_mem.v ***
`timescale 1ns/1ps
`default_nettype none

module eth_map_mem #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // Clock
   input wire clk,
   // Write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [WIDTH-1:0] wr_data,
   // Read port, data registered
   input wire [AW-1:0] rd_addr,
   output reg [WIDTH-1:0] rd_data
);

   // No reset: contents power up uninitialised
   reg [WIDTH-1:0] mem [0:DEPTH-1];

   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule // eth_map_mem

`default_nettype wire

// *** bench/eth_tail_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module eth_tail_monitor #(
   parameter DEPTH = 32
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic CRC_BUSY
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   wire map_wr = REG_WR && REG_ADDR >= 8'h5f && REG_ADDR <= 8'h7e;
   a_read_answer: assert property (REG_RD |-> ##2 REG_RVALID)
      else $error("read got no answer");
   a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD, 2))
      else $error("answer without read");
   a_rdata_hold: assert property (!REG_RVALID |-> $stable(REG_RDATA))
      else $error("read data moved");
   a_unmapped_zero: assert property
      (REG_RD && REG_ADDR < 8'h5f |-> ##2 REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_reserved_zero: assert property
      (REG_RD && REG_ADDR == 8'h7e |-> ##2 REG_RDATA[7:4] == 4'h0)
      else $error("reserved bits not zero");
   a_busy_on_write: assert property (map_wr |=> CRC_BUSY)
      else $error("no recompute after write");
   a_busy_cause: assert property ($rose(CRC_BUSY) |-> $past(map_wr))
      else $error("recompute without write");
   a_busy_bounded: assert property
      ($rose(CRC_BUSY) |-> ##[1:400] !CRC_BUSY)
      else $error("recompute never ends");
   c_offset_write: cover property (REG_WR && REG_ADDR == 8'h7e);
   c_sum_read: cover property (REG_RD && REG_ADDR == 8'h7f);
   c_sum_done: cover property ($fell(CRC_BUSY));
endmodule // eth_tail_monitor
bind eth_tail_regs eth_tail_monitor #(.DEPTH(DEPTH)) i_eth_tail_monitor (
   .REF_CLK(REF_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CRC_BUSY(CRC_BUSY));
`default_nettype wire

// *** bench/eth_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module eth_host_model (
   // Clock
   input wire logic clk,
   // Register port toward the device
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // Idle lines show the inverse so no stale value can be relied on
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      addr <= ~a;
      wdata <= ~d;
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [8:0] q);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      addr <= ~a;
      rd <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      q = {rvalid, rdata};
   endtask
endmodule // eth_host_model
`default_nettype wire

// *** bench/eth_tail_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   miscompares++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module eth_tail_regs_tb_top;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, reg_rvalid, crc_busy;
   logic [7:0] m [32];
   logic [8:0] q;
   int miscompares = 0;
   int total_checks = 0;
   eth_tail_regs i_eth_tail_regs (.REF_CLK(ref_clk), .RESET(reset),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
      .CRC_BUSY(crc_busy));
   eth_host_model i_eth_host_model (.clk(ref_clk), .addr(reg_addr),
      .wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd), .rdata(reg_rdata),
      .rvalid(reg_rvalid));
   initial forever #2.5 ref_clk = ~ref_clk;
   function automatic logic [7:0] map_sum();
      logic [7:0] c;
      c = 8'hff;
      for (int i = 0; i < 32; i++) begin
         c ^= m[i];
         repeat (8) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
      end
      return c;
   endfunction
   task automatic run_round(input logic [7:0] k);
      for (int i = 0; i < 32; i++) begin
         m[i] = 8'(i * 8'h1d) ^ k;
         i_eth_host_model.wr_reg(8'h5f + 8'(i), m[i]);
      end
      m[31] &= 8'h0f;
      i_eth_host_model.wr_reg(8'h7f, ~k);
      i_eth_host_model.wr_reg(8'h20, k);
      for (int n = 0; n < 200 && crc_busy === 1'b1; n++) @(posedge ref_clk);
      `CHK(crc_busy, 1'b0)
      for (int i = 27; i < 32; i++) begin
         i_eth_host_model.rd_reg(8'h5f + 8'(i), q);
         `CHK(q, {1'b1, m[i]})
      end
      i_eth_host_model.rd_reg(8'h7f, q);
      `CHK(q, {1'b1, map_sum()})
      i_eth_host_model.rd_reg(8'h20, q);
      `CHK(q, 9'h100)
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      run_round(8'h5a);
      run_round(8'ha5);
      end_of_test();
   end
   // Two rounds need well under 1000 cycles; allow several times that
   initial begin
      #20000;
      miscompares++;
      end_of_test();
   end
endmodule // eth_tail_regs_tb_top
`default_nettype wire
